// *** core/vtp_ctrl.sv ***
// Vector table placement control with APB register access
// Assumes fuse and lock levels arrive asynchronously; core on ref_clk
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vtp_regs.svh"
module vtp_ctrl (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output var logic [31:0] prdata_q,
  output var logic pready_q,
  output var logic pslverr_q,
  input wire logic [12:0] pc_word,
  input wire logic instr_done,
  input wire logic [4:0] vec_num,
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic app_boot_lock_bit,
  input wire logic boot_boot_lock_bit,
  output var logic [12:0] vec_addr_q,
  output var logic [12:0] vec_base_q,
  output var logic [12:0] reset_addr_q,
  output var logic irq_block_q,
  output var logic pullup_off_q
);
  vtp_seq_if sq ();

  logic [4:0] fz_meta_q;
  logic [4:0] fz_q;
  logic pud_q;
  logic dbg_q;
  logic mask_q;

  // Fuses and locks are pins: two stages before use
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fz_meta_q <= `VTP_FUSE_RST;
      fz_q <= `VTP_FUSE_RST;
    end else begin
      fz_meta_q <= {app_boot_lock_bit, boot_boot_lock_bit,
        boot_reset_fuse, boot_size_fuses};
      fz_q <= fz_meta_q;
    end
  end

  wire logic [1:0] size_w = fz_q[`VTP_FZ_SIZE];
  wire logic brst_prog_w = !fz_q[`VTP_FZ_BRST];
  wire logic blck_prog_w = !fz_q[`VTP_FZ_BLCK];
  wire logic alck_prog_w = !fz_q[`VTP_FZ_ALCK];

  wire vtp_pkg::vtp_waddr_t boot_start_w =
    (size_w == 2'h0) ? `VTP_BOOT_SZ0 :
    (size_w == 2'h1) ? `VTP_BOOT_SZ1 :
    (size_w == 2'h2) ? `VTP_BOOT_SZ2 : `VTP_BOOT_SZ3;

  // table base follows the select bit
  wire vtp_pkg::vtp_waddr_t base_w =
    sq.sel_nx ? boot_start_w : `VTP_RESET_APP;

  // base plus two words per vector
  wire vtp_pkg::vtp_waddr_t vaddr_w =
    13'(base_w + {7'h00, vec_num, 1'b0});

  // reset entry from the reset fuse
  wire vtp_pkg::vtp_waddr_t rst_w =
    brst_prog_w ? boot_start_w : `VTP_RESET_APP;

  wire logic in_boot_w = (pc_word >= boot_start_w);

  // app code with boot vectors and app lock
  wire logic app_blk_w = sq.sel_nx && alck_prog_w && !in_boot_w;
  // boot code with app vectors and boot lock
  wire logic boot_blk_w = !sq.sel_nx && blck_prog_w && in_boot_w;

  // separate gate, status I-bit never written
  wire logic blk_w = sq.mask_nx || app_blk_w || boot_blk_w;

  // APB decode; writes land on the access edge
  wire logic setup_w = psel && !penable;
  wire logic acc_w = psel && penable && pready_q;
  wire logic hit_ctrl_w = (paddr == `VTP_ADDR_CTRL);
  wire logic hit_stat_w = (paddr == `VTP_ADDR_STAT);
  wire logic hit_vec_w = (paddr == `VTP_ADDR_VEC);
  wire logic hit_w = hit_ctrl_w || hit_stat_w || hit_vec_w;
  wire logic wr_ctrl_w = acc_w && pwrite && hit_ctrl_w && pstrb[0];

  // software pair of writes arrives here
  assign sq.open_req = wr_ctrl_w && pwdata[`VTP_BIT_VCE];
  assign sq.sel_wr = wr_ctrl_w && !pwdata[`VTP_BIT_VCE];
  assign sq.sel_val = pwdata[`VTP_BIT_SEL];
  assign sq.instr_done = instr_done;

  wire logic [7:0] ctrl_rd_w = {dbg_q, 2'h0, pud_q, 2'h0,
    sq.sel, sq.ce};
  wire logic [31:0] stat_rd_w = {23'h000000, fz_q, irq_block_q,
    mask_q, sq.sel, sq.ce};
  wire logic [31:0] vec_rd_w = {3'h0, reset_addr_q, 3'h0, vec_base_q};
  wire logic [31:0] rdata_w =
    hit_ctrl_w ? {24'h000000, ctrl_rd_w} :
    hit_stat_w ? stat_rd_w :
    hit_vec_w ? vec_rd_w : 32'h00000000;

  vtp_seq u_seq (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sq(sq.seq)
  );

  // Zero-wait slave: ready is raised for the access cycle only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w && !hit_w;
      prdata_q <= setup_w ? rdata_w : 32'h00000000;
    end
  end

  // Plain control bits; the enable pair lives in the sequencer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pud_q <= 1'(`VTP_CTRL_RST >> `VTP_BIT_PUD);
      dbg_q <= 1'b0;
    end else if (wr_ctrl_w) begin
      pud_q <= pwdata[`VTP_BIT_PUD];
      dbg_q <= pwdata[`VTP_BIT_DBG];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mask_q <= 1'b0;
      irq_block_q <= 1'b0;
      pullup_off_q <= 1'b0;
      vec_base_q <= `VTP_RESET_APP;
      vec_addr_q <= `VTP_RESET_APP;
      reset_addr_q <= `VTP_RESET_APP;
    end else begin
      mask_q <= sq.mask_nx;
      irq_block_q <= blk_w;
      pullup_off_q <= wr_ctrl_w ? pwdata[`VTP_BIT_PUD] : pud_q;
      vec_base_q <= base_w;
      vec_addr_q <= vaddr_w;
      reset_addr_q <= rst_w;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_ctrl_write(logic [31:0] v);
    setup_w && pwrite && hit_ctrl_w && pstrb[0] && pwdata == v
      ##1 acc_w;
  endsequence

  a_mask_start: assert property (
    sq.open_req |=> irq_block_q && sq.ce)
    else $error("interrupts not masked when enable set");
  a_unlock_time: assert property (
    s_ctrl_write(32'h00000001) ##1 (!sq.open_req && !sq.sel_wr
      && !app_blk_w && !boot_blk_w)[*4] |=> !irq_block_q)
    else $error("mask held past four cycles");
  a_reset_app: assert property (
    !brst_prog_w |=> reset_addr_q == 13'h0000)
    else $error("reset entry not zero with fuse unprogrammed");
  a_reset_boot: assert property (
    brst_prog_w && size_w == 2'h0 |=> reset_addr_q == 13'h1C00)
    else $error("boot reset entry wrong");
  a_vec_last: assert property (
    sq.sel_nx && size_w == 2'h0 && vec_num == 5'h16
      |=> vec_addr_q == 13'h1C2C)
    else $error("last relocated vector misplaced");
  a_vec_first: assert property (
    sq.sel_nx && size_w == 2'h0 && vec_num == 5'h01
      |=> vec_addr_q == 13'h1C02)
    else $error("first relocated vector misplaced");
  a_vec_flash: assert property (
    !sq.sel_nx && vec_num == 5'h01 |=> vec_addr_q == 13'h0002)
    else $error("vector not at flash start");
  a_app_lock: assert property (
    sq.sel_nx && alck_prog_w && pc_word < boot_start_w
      |=> irq_block_q)
    else $error("app code not blocked under app lock");
  a_boot_lock: assert property (
    !sq.sel_nx && blck_prog_w && pc_word >= boot_start_w
      |=> irq_block_q)
    else $error("boot code not blocked under boot lock");
  a_pud_follow: assert property (
    s_ctrl_write(32'h00000010) |=> pullup_off_q ##1 pullup_off_q)
    else $error("pull-up disable not applied");
  a_apb_answer: assert property (
    setup_w |=> pready_q ##1 !pready_q)
    else $error("ready not a single access cycle");

  sequence s_open_write;
    sq.open_req && !sq.sel_wr;
  endsequence

  sequence s_sel_write;
    sq.sel_wr && sq.ce;
  endsequence

  a_ready_quiet: assert property (
    !setup_w |=> !pready_q)
    else $error("ready without a setup cycle");

  a_rdata_idle: assert property (
    !pready_q |-> prdata_q == 32'h00000000)
    else $error("read data outside access cycle");

  a_err_unmapped: assert property (
    setup_w && !hit_w |=> pslverr_q && pready_q)
    else $error("unmapped address not flagged");

  a_err_mapped: assert property (
    setup_w && hit_w |=> !pslverr_q)
    else $error("mapped address flagged as error");

  a_err_data: assert property (
    pslverr_q |-> prdata_q == 32'h00000000)
    else $error("error answer carries data");

  a_rd_ctrl_width: assert property (
    setup_w && !pwrite && hit_ctrl_w |=> prdata_q[31:8] == 24'h000000)
    else $error("control read wider than a byte");

  a_sel_kept: assert property (
    sq.sel_wr && !sq.ce |=> sq.sel == $past(sq.sel))
    else $error("select moved by write outside window");

  a_open_keeps_sel: assert property (
    s_open_write |=> sq.sel == $past(sq.sel))
    else $error("enable write changed select");

  a_ce_cleared: assert property (
    s_sel_write |=> !sq.ce)
    else $error("enable not cleared by select write");

  a_win_reload: assert property (
    sq.ce && sq.open_req |=> sq.ce)
    else $error("window not reloaded by enable rewrite");

  a_mask_gate: assert property (
    mask_q |-> irq_block_q)
    else $error("mask active but interrupts not blocked");

  a_mask_idle: assert property (
    !sq.mask_nx |=> !mask_q)
    else $error("mask outlived the sequence");

  a_no_block: assert property (
    !sq.mask_nx && !alck_prog_w && !blck_prog_w |=> !irq_block_q)
    else $error("interrupts blocked with no cause");

  a_base_app: assert property (
    !sq.sel_nx |=> vec_base_q == 13'h0000)
    else $error("table base not at flash start");

  a_base_sz1: assert property (
    sq.sel_nx && size_w == 2'h1 |=> vec_base_q == 13'h1E00)
    else $error("boot base wrong for size one");

  a_base_sz2: assert property (
    sq.sel_nx && size_w == 2'h2 |=> vec_base_q == 13'h1F00)
    else $error("boot base wrong for size two");

  a_base_sz3: assert property (
    sq.sel_nx && size_w == 2'h3 |=> vec_base_q == 13'h1F80)
    else $error("boot base wrong for size three");

  a_rst_sz3: assert property (
    brst_prog_w && size_w == 2'h3 |=> reset_addr_q == 13'h1F80)
    else $error("boot reset entry wrong for smallest section");

  a_vec_sz1: assert property (
    sq.sel_nx && size_w == 2'h1 && vec_num == 5'h01
      |=> vec_addr_q == 13'h1E02)
    else $error("relocated vector offset wrong");

  a_vec_app_last: assert property (
    !sq.sel_nx && vec_num == 5'h16 |=> vec_addr_q == 13'h002C)
    else $error("last flash vector misplaced");

  a_pud_clear: assert property (
    s_ctrl_write(32'h00000000) |=> !pullup_off_q)
    else $error("pull-up disable not released");
endmodule
`default_nettype wire

// *** include/vtp_regs.svh ***
// Register map, field positions and counts of the vector placement block
// Assumes inclusion by bare name from include/
`ifndef VTP_REGS_SVH
`define VTP_REGS_SVH

`define VTP_AW 12
`define VTP_ADDR_CTRL 12'h000
`define VTP_ADDR_STAT 12'h004
`define VTP_ADDR_VEC 12'h008

`define VTP_CTRL_RST 8'h00
`define VTP_BIT_VCE 0
`define VTP_BIT_SEL 1
`define VTP_BIT_PUD 4
`define VTP_BIT_DBG 7

`define VTP_WIN_CYC 3'h4

`define VTP_FUSE_RST 5'h1F
`define VTP_FZ_SIZE 1:0
`define VTP_FZ_BRST 2
`define VTP_FZ_BLCK 3
`define VTP_FZ_ALCK 4

`define VTP_RESET_APP 13'h0000
`define VTP_BOOT_SZ0 13'h1C00
`define VTP_BOOT_SZ1 13'h1E00
`define VTP_BOOT_SZ2 13'h1F00
`define VTP_BOOT_SZ3 13'h1F80

`endif

// *** include/vtp_pkg.sv ***
// Types of the vector placement block
// Assumes nothing beyond a SystemVerilog compiler
package vtp_pkg;
  typedef enum logic [1:0] {
    VTP_IDLE,
    VTP_OPEN,
    VTP_HOLD
  } vtp_seq_state_t;
  typedef logic [12:0] vtp_waddr_t;
endpackage

// *** include/vtp_seq_if.sv ***
// Carrier between the register side and the change sequencer
// Assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface vtp_seq_if;
  logic open_req;
  logic sel_wr;
  logic sel_val;
  logic instr_done;
  logic ce;
  logic sel;
  logic sel_nx;
  logic mask_nx;
  modport seq (input open_req, input sel_wr, input sel_val,
    input instr_done, output ce, output sel, output sel_nx,
    output mask_nx);
  modport ctrl (output open_req, output sel_wr, output sel_val,
    output instr_done, input ce, input sel, input sel_nx,
    input mask_nx);
endinterface
`default_nettype wire

// *** core/vtp_seq.sv ***
// Timed change sequence for the vector select bit
// Assumes one-cycle write pulses from the register side
`timescale 1ns/1ps
`default_nettype none
`include "vtp_regs.svh"
module vtp_seq (
  input wire logic ref_clk,
  input wire logic nrst,
  vtp_seq_if.seq sq
);
  vtp_pkg::vtp_seq_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic sel_q, sel_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    case (state_q)
      vtp_pkg::VTP_OPEN: begin
        if (sq.open_req) begin
          cnt_d = `VTP_WIN_CYC;
        end else if (sq.sel_wr) begin
          sel_d = sq.sel_val;
          state_d = vtp_pkg::VTP_HOLD;
        end else if (cnt_q == 3'h1) begin
          state_d = vtp_pkg::VTP_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      vtp_pkg::VTP_HOLD: begin
        if (sq.open_req) begin
          state_d = vtp_pkg::VTP_OPEN;
          cnt_d = `VTP_WIN_CYC;
        end else if (sq.instr_done) begin
          state_d = vtp_pkg::VTP_IDLE;
        end
      end
      vtp_pkg::VTP_IDLE: begin
        if (sq.open_req) begin
          state_d = vtp_pkg::VTP_OPEN;
          cnt_d = `VTP_WIN_CYC;
        end
      end
      default: begin
        state_d = vtp_pkg::VTP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= vtp_pkg::VTP_IDLE;
      cnt_q <= 3'h0;
      sel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
    end
  end

  assign sq.ce = (state_q == vtp_pkg::VTP_OPEN);
  assign sq.sel = sel_q;
  assign sq.sel_nx = sel_d;
  assign sq.mask_nx = (state_d != vtp_pkg::VTP_IDLE);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_quiet_window;
    sq.open_req ##1 (!sq.open_req && !sq.sel_wr)[*4];
  endsequence

  a_open_window: assert property (
    sq.open_req |=> sq.ce && cnt_q == 3'h4)
    else $error("window not opened with full count");
  a_ce_expires: assert property (
    s_quiet_window |=> !sq.ce && state_q == vtp_pkg::VTP_IDLE)
    else $error("window outlived four cycles");
  a_sel_guarded: assert property (
    !sq.ce |=> $stable(sel_q))
    else $error("select moved outside window");
  a_sel_taken: assert property (
    sq.ce && sq.sel_wr && !sq.open_req |=>
      sel_q == $past(sq.sel_val) && !sq.ce)
    else $error("select write not taken");
  a_mask_hold: assert property (
    state_q == vtp_pkg::VTP_HOLD && !sq.instr_done |-> sq.mask_nx)
    else $error("mask dropped before next instruction");
endmodule
`default_nettype wire

// *** dv/vtp_core_model.sv ***
// Core model: retires instructions and asks for vectors
// Assumes ref_clk shared with the control block
`timescale 1ns/1ps
`default_nettype none
module vtp_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic [12:0] pc_set,
  input wire logic [4:0] vec_set,
  output var logic [12:0] pc_word,
  output var logic instr_done,
  output var logic [4:0] vec_num
);
  // Retire every other cycle; stall models a slow core
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      instr_done <= 1'b0;
      pc_word <= 13'h0000;
      vec_num <= 5'h01;
    end else begin
      instr_done <= !stall && !instr_done;
      pc_word <= pc_set;
      vec_num <= vec_set;
    end
  end
endmodule
`default_nettype wire

// *** dv/vtp_ctrl_test.sv ***
// Self-checking bench of the vector placement block
// Assumes the core model drives pc, retire pulses and vector number
`timescale 1ns/1ps
`default_nettype none
`include "vtp_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module vtp_ctrl_test;
  localparam logic [11:0] A_CTL = `VTP_ADDR_CTRL;
  localparam logic [11:0] A_ST = `VTP_ADDR_STAT;
  localparam logic [11:0] A_VEC = `VTP_ADDR_VEC;
  localparam logic [12:0] BSTART [4] = '{13'h1C00, `VTP_BOOT_SZ1, `VTP_BOOT_SZ2, `VTP_BOOT_SZ3};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, look = 1'b0, stall = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, instr_done, irq_block_q, pullup_off_q;
  logic [12:0] pc_word, vec_addr_q, vec_base_q, reset_addr_q;
  logic [4:0] vec_num;
  logic boot_reset_fuse = 1'b0, app_boot_lock_bit = 1'b1, boot_boot_lock_bit = 1'b1;
  logic [1:0] boot_size_fuses = 2'h0;
  logic [12:0] pc_set = 13'h0000;
  logic [4:0] vec_set = 5'h01;
  logic [31:0] lfsr = 32'h83FA;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int num_errors = 0;
  int checks_done = 0;

  always #5 ref_clk = ~ref_clk;

  vtp_ctrl dut (.ref_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata_q, .pready_q, .pslverr_q, .pc_word, .instr_done, .vec_num, .boot_reset_fuse,
    .boot_size_fuses, .app_boot_lock_bit, .boot_boot_lock_bit, .vec_addr_q, .vec_base_q,
    .reset_addr_q, .irq_block_q, .pullup_off_q);
  vtp_core_model core (.ref_clk, .nrst, .stall, .pc_set, .vec_set, .pc_word, .instr_done,
    .vec_num);

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Oldest note pairs with each read answer or output look
  always @(posedge ref_clk) begin
    if ((psel && penable && pready_q && !pwrite) || look) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[FAIL] %0t got %h exp %h", $time, 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        if (look) begin
          `CHK({18'h0, pullup_off_q, irq_block_q, vec_addr_q}, e)
        end else begin
          `CHK({pslverr_q, prdata_q}, e)
        end
      end
    end
  end

  // Request held until pready seen high at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [32:0] x);
    int n;
    if (!w) exp_q.push_back(x);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    apb(a, 1'b0, 32'h0, x);
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic peek(input logic [32:0] x);
    exp_q.push_back(x);
    look <= 1'b1;
    @(posedge ref_clk);
    look <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Random pc alternates between application and boot code
  task automatic scan(input logic [12:0] va, input logic blk_in_boot);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      pc_set <= i[0] ? {3'h7, lfsr[9:0]} : {1'b0, lfsr[11:0]};
      idle(5);
      peek({18'h0, 1'b1, i[0] == blk_in_boot, va});
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(4);
    rd(A_CTL, 33'h0);
    rd(A_VEC, {4'h0, 13'h1C00, 16'h0});
    rd(12'h00C, {1'b1, 32'h0});
    wr(A_CTL, 32'h92);
    rd(A_CTL, 33'h90);
    idle(1);
    peek({18'h0, 2'b10, 13'h0002});
    pstrb <= 4'hE;
    wr(A_CTL, 32'h0);
    pstrb <= 4'hF;
    rd(A_CTL, 33'h90);
    stall <= 1'b1;
    wr(A_CTL, 32'h11);
    wr(A_CTL, 32'h12);
    rd(A_CTL, 33'h12);
    idle(6);
    rd(A_ST, 33'h18E);
    stall <= 1'b0;
    idle(4);
    rd(A_ST, 33'h182);
    rd(A_VEC, {4'h0, 13'h1C00, 3'h0, 13'h1C00});
    for (int v = 1; v <= 22; v++) begin
      vec_set <= v[4:0];
      idle(3);
      peek({18'h0, 2'b10, 13'h1C00 + {v[11:0], 1'b0}});
    end
    wr(A_CTL, 32'h13);
    rd(A_ST, 33'h18F);
    idle(6);
    rd(A_CTL, 33'h12);
    rd(A_ST, 33'h182);
    wr(A_CTL, 32'h10);
    rd(A_CTL, 33'h12);
    app_boot_lock_bit <= 1'b0;
    scan(13'h1C2C, 1'b0);
    app_boot_lock_bit <= 1'b1;
    boot_boot_lock_bit <= 1'b0;
    wr(A_CTL, 32'h11);
    wr(A_CTL, 32'h10);
    idle(8);
    scan(13'h002C, 1'b1);
    for (int s = 0; s < 8; s++) begin
      {boot_reset_fuse, boot_size_fuses} <= s[2:0];
      idle(5);
      rd(A_VEC, {4'h0, s[2] ? 13'h0 : BSTART[s[1:0]], 16'h0});
    end
    idle(2);
    close_out();
  end
endmodule
`default_nettype wire
